// ==== design/ptmc_pkg.sv ====
package ptmc_pkg;
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 4;

	// Register offsets (byte addresses)
	localparam logic [11:0] OFS_INT_FLAGS = 12'h000;
	localparam logic [11:0] OFS_TIMER_CTRL = 12'h004;
	localparam logic [11:0] OFS_TIMER_COUNT = 12'h008;
	localparam logic [11:0] OFS_DIV_LIMIT = 12'h00c;
	localparam logic [11:0] OFS_DIV_COUNT = 12'h010;
	localparam logic [11:0] OFS_MATCH_CTRL = 12'h014;
	localparam logic [11:0] OFS_MATCH_VAL0 = 12'h018;
	localparam logic [11:0] OFS_MATCH_VAL1 = 12'h01c;
	localparam logic [11:0] OFS_MATCH_VAL2 = 12'h020;
	localparam logic [11:0] OFS_MATCH_VAL3 = 12'h024;
	localparam logic [11:0] OFS_CAPT_CTRL = 12'h028;
	localparam logic [11:0] OFS_CAPT_SNAP = 12'h02c;
	localparam logic [11:0] OFS_EXT_CTRL = 12'h03c;
	localparam logic [11:0] OFS_SRC_CTRL = 12'h070;
	localparam logic [11:0] OFS_PWM_CTRL = 12'h074;

	// Reset value of every used bit
	localparam logic [31:0] RESET_VAL = 32'h0000_0000;

	// Field positions
	localparam int TCR_ENABLE = 0;
	localparam int TCR_RESET = 1;
	localparam int MCR_INT = 0;
	localparam int MCR_RESET = 1;
	localparam int MCR_STOP = 2;
	localparam int MCR_STRIDE = 3;
	localparam int CCR_RISE = 0;
	localparam int CCR_FALL = 1;
	localparam int CCR_INT = 2;
	localparam int EMR_ACT_BASE = 4;
	localparam int IR_CAPT = 4;
	localparam int COUNT_SOURCE_CONTROL_SEL_LSB = 2;

	// Used widths
	localparam int IR_W = 5;
	localparam int TCR_W = 2;
	localparam int MCR_W = 12;
	localparam int CCR_W = 3;
	localparam int EMR_W = 12;
	localparam int COUNT_SOURCE_CONTROL_W = 4;
	localparam int PWMC_W = 4;

	// Count source selection
	typedef enum logic [1:0] {
		CM_TIMER = 2'b00,
		CM_RISE = 2'b01,
		CM_FALL = 2'b10,
		CM_BOTH = 2'b11
	} ptmc_mode_type;

	// Compare output action on match
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_LOW = 2'b01,
		ACT_HIGH = 2'b10,
		ACT_TOGGLE = 2'b11
	} ptmc_act_type;

	// Counter-mode input select code for the capture input
	localparam logic [1:0] SEL_CAPTURE = 2'b00;
endpackage : ptmc_pkg

// ==== design/ptmc_cmp_if.sv ====
`timescale 1ns/1ps
interface ptmc_cmp_if;
	logic [31:0] count;
	logic [31:0] match_value [4];
	logic [3:0] hit;
	logic [3:0] at_or_above;

	modport owner (output count, output match_value, input hit, input at_or_above);
	modport comparer (input count, input match_value, output hit, output at_or_above);
endinterface : ptmc_cmp_if

// ==== design/ptmc_match_unit.sv ====
`timescale 1ns/1ps
module ptmc_match_unit (
	// Count and match values in, comparison results out
	ptmc_cmp_if.comparer cmp
);
	import ptmc_pkg::*;

	////////////////////////////////////////////////////////////////
	// One equality and one magnitude comparator per channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			assign cmp.hit[g] = (cmp.count == cmp.match_value[g]);
			assign cmp.at_or_above[g] = (cmp.count >= cmp.match_value[g]);
		end
	endgenerate
endmodule : ptmc_match_unit

// ==== design/ptmc_edge_sync.sv ====
`timescale 1ns/1ps
module ptmc_edge_sync (
	// Clock and reset
	input logic i_clk,
	input logic i_rst,
	// Asynchronous pin
	input logic i_pin,
	// Edge pulses, one cycle each
	output logic o_rise,
	output logic o_fall
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;
	logic nxt_meta;
	logic nxt_sync;
	logic nxt_last;

	////////////////////////////////////////////////////////////////
	// Two-stage synchroniser followed by an edge detector
	always_comb begin
		nxt_meta = i_pin;
		nxt_sync = meta_ff;
		nxt_last = sync_ff;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			last_ff <= nxt_last;
		end
	end

	// Edge pulses from the synchronised level only
	assign o_rise = sync_ff & ~last_ff;
	assign o_fall = ~sync_ff & last_ff;
endmodule : ptmc_edge_sync

// ==== design/ptmc_timer.sv ====
`timescale 1ns/1ps
module ptmc_timer (
	// Clock and reset
	input logic i_clk,
	input logic i_rst,
	// Register port
	input logic i_bus_wr,
	input logic i_bus_rd,
	input logic [ptmc_pkg::ADDR_W-1:0] i_bus_addr,
	input logic [ptmc_pkg::DATA_W-1:0] i_bus_wdata,
	output logic [ptmc_pkg::DATA_W-1:0] o_bus_rdata,
	output logic o_bus_rvalid,
	// Pins
	input logic i_capture_input,
	output logic [3:0] o_compare_outputs
);
	import ptmc_pkg::*;

	logic [IR_W-1:0] flags_ff, nxt_flags;
	logic [TCR_W-1:0] tctrl_ff, nxt_tctrl;
	logic [31:0] tcount_ff, nxt_tcount;
	logic [31:0] dlimit_ff, nxt_dlimit;
	logic [31:0] dcount_ff, nxt_dcount;
	logic [MCR_W-1:0] mctrl_ff, nxt_mctrl;
	logic [31:0] mval_ff [NUM_CH];
	logic [31:0] nxt_mval [NUM_CH];
	logic [CCR_W-1:0] cctrl_ff, nxt_cctrl;
	logic [31:0] snap_ff, nxt_snap;
	logic [EMR_W-1:0] ectrl_ff, nxt_ectrl;
	logic [COUNT_SOURCE_CONTROL_W-1:0] src_ff, nxt_src;
	logic [PWMC_W-1:0] pwm_ff, nxt_pwm;
	logic [3:0] out_ff, nxt_out;
	logic [31:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;

	logic cap_rise, cap_fall;
	logic count_edge, advance, tick, cap_evt;
	logic [3:0] match_evt;
	logic any_reset, any_stop;
	ptmc_mode_type mode;
	ptmc_cmp_if cmp ();

	////////////////////////////////////////////////////////////////
	// Capture pin synchroniser and comparators
	ptmc_edge_sync u_cap_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_capture_input),
		.o_rise(cap_rise),
		.o_fall(cap_fall)
	);

	ptmc_match_unit u_match (
		.cmp(cmp.comparer)
	);

	assign cmp.count = tcount_ff;
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_mv
			assign cmp.match_value[g] = mval_ff[g];
			assign match_evt[g] = tick & cmp.hit[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Count source, divider tick and event decode
	always_comb begin
		mode = ptmc_mode_type'(src_ff[1:0]);
		if (mode == CM_TIMER) begin
			count_edge = 1'b1;
		end else if (src_ff[COUNT_SOURCE_CONTROL_SEL_LSB +: 2] == SEL_CAPTURE) begin
			count_edge = (mode[0] & cap_rise) | (mode[1] & cap_fall);
		end else begin
			count_edge = 1'b0;
		end
		advance = tctrl_ff[TCR_ENABLE] & ~tctrl_ff[TCR_RESET] & count_edge;
		tick = advance & (dcount_ff == dlimit_ff);
		cap_evt = (cap_rise & cctrl_ff[CCR_RISE]) | (cap_fall & cctrl_ff[CCR_FALL]);
		any_reset = 1'b0;
		any_stop = 1'b0;
		for (int n = 0; n < NUM_CH; n++) begin
			any_reset = any_reset | (match_evt[n] & mctrl_ff[n*MCR_STRIDE+MCR_RESET]);
			any_stop = any_stop | (match_evt[n] & mctrl_ff[n*MCR_STRIDE+MCR_STOP]);
		end
	end

	////////////////////////////////////////////////////////////////
	// Register file next values: hardware updates, then bus writes, then match and capture events
	always_comb begin
		nxt_flags = flags_ff;
		nxt_tctrl = tctrl_ff;
		nxt_tcount = tcount_ff;
		nxt_dlimit = dlimit_ff;
		nxt_dcount = dcount_ff;
		nxt_mctrl = mctrl_ff;
		nxt_mval = mval_ff;
		nxt_cctrl = cctrl_ff;
		nxt_snap = snap_ff;
		nxt_ectrl = ectrl_ff;
		nxt_src = src_ff;
		nxt_pwm = pwm_ff;
		// Divider and timer count
		if (tctrl_ff[TCR_RESET]) begin
			nxt_dcount = RESET_VAL;
			nxt_tcount = RESET_VAL;
		end else if (advance) begin
			if (tick) begin
				nxt_dcount = RESET_VAL;
				if (any_reset) begin
					nxt_tcount = RESET_VAL;
				end else if (!any_stop) begin
					nxt_tcount = tcount_ff + 32'h0000_0001;
				end
			end else begin
				nxt_dcount = dcount_ff + 32'h0000_0001;
			end
		end
		if (any_stop) begin
			nxt_tctrl[TCR_ENABLE] = 1'b0;
		end
		// Capture snapshot
		if (cap_evt) begin
			nxt_snap = tcount_ff;
		end
		// Bus writes; W1C on flags, snapshot read-only, other registers plain
		if (i_bus_wr) begin
			case (i_bus_addr)
				OFS_INT_FLAGS: nxt_flags = flags_ff & ~i_bus_wdata[IR_W-1:0];
				OFS_TIMER_CTRL: nxt_tctrl = i_bus_wdata[TCR_W-1:0];
				OFS_TIMER_COUNT: nxt_tcount = i_bus_wdata;
				OFS_DIV_LIMIT: nxt_dlimit = i_bus_wdata;
				OFS_DIV_COUNT: nxt_dcount = i_bus_wdata;
				OFS_MATCH_CTRL: nxt_mctrl = i_bus_wdata[MCR_W-1:0];
				OFS_MATCH_VAL0: nxt_mval[0] = i_bus_wdata;
				OFS_MATCH_VAL1: nxt_mval[1] = i_bus_wdata;
				OFS_MATCH_VAL2: nxt_mval[2] = i_bus_wdata;
				OFS_MATCH_VAL3: nxt_mval[3] = i_bus_wdata;
				OFS_CAPT_CTRL: nxt_cctrl = i_bus_wdata[CCR_W-1:0];
				OFS_EXT_CTRL: nxt_ectrl = i_bus_wdata[EMR_W-1:0];
				OFS_SRC_CTRL: nxt_src = i_bus_wdata[COUNT_SOURCE_CONTROL_W-1:0];
				OFS_PWM_CTRL: nxt_pwm = i_bus_wdata[PWMC_W-1:0];
				default: ;
			endcase
		end
		// Events set flags and move outputs after the write, so they win
		for (int n = 0; n < NUM_CH; n++) begin
			if (match_evt[n] & mctrl_ff[n*MCR_STRIDE+MCR_INT]) begin
				nxt_flags[n] = 1'b1;
			end
			if (match_evt[n]) begin
				case (ptmc_act_type'(ectrl_ff[EMR_ACT_BASE+2*n +: 2]))
					ACT_LOW: nxt_ectrl[n] = 1'b0;
					ACT_HIGH: nxt_ectrl[n] = 1'b1;
					ACT_TOGGLE: nxt_ectrl[n] = ~ectrl_ff[n];
					default: ;
				endcase
			end
		end
		if (cap_evt & cctrl_ff[CCR_INT]) begin
			nxt_flags[IR_CAPT] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Compare outputs: PWM level or external output state
	always_comb begin
		for (int n = 0; n < NUM_CH; n++) begin
			nxt_out[n] = pwm_ff[n] ? cmp.at_or_above[n] : nxt_ectrl[n];
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data, registered one cycle after the strobe
	always_comb begin
		nxt_rvalid = i_bus_rd;
		nxt_rdata = 32'h0000_0000;
		if (i_bus_rd) begin
			case (i_bus_addr)
				OFS_INT_FLAGS: nxt_rdata = {27'h0, flags_ff};
				OFS_TIMER_CTRL: nxt_rdata = {30'h0, tctrl_ff};
				OFS_TIMER_COUNT: nxt_rdata = tcount_ff;
				OFS_DIV_LIMIT: nxt_rdata = dlimit_ff;
				OFS_DIV_COUNT: nxt_rdata = dcount_ff;
				OFS_MATCH_CTRL: nxt_rdata = {20'h0, mctrl_ff};
				OFS_MATCH_VAL0: nxt_rdata = mval_ff[0];
				OFS_MATCH_VAL1: nxt_rdata = mval_ff[1];
				OFS_MATCH_VAL2: nxt_rdata = mval_ff[2];
				OFS_MATCH_VAL3: nxt_rdata = mval_ff[3];
				OFS_CAPT_CTRL: nxt_rdata = {29'h0, cctrl_ff};
				OFS_CAPT_SNAP: nxt_rdata = snap_ff;
				OFS_EXT_CTRL: nxt_rdata = {20'h0, ectrl_ff};
				OFS_SRC_CTRL: nxt_rdata = {28'h0, src_ff};
				OFS_PWM_CTRL: nxt_rdata = {28'h0, pwm_ff};
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags_ff <= '0;
			tctrl_ff <= '0;
			tcount_ff <= RESET_VAL;
			dlimit_ff <= RESET_VAL;
			dcount_ff <= RESET_VAL;
			mctrl_ff <= '0;
			for (int n = 0; n < NUM_CH; n++) begin
				mval_ff[n] <= RESET_VAL;
			end
			cctrl_ff <= '0;
			snap_ff <= RESET_VAL;
			ectrl_ff <= '0;
			src_ff <= '0;
			pwm_ff <= '0;
			out_ff <= 4'h0;
			rdata_ff <= RESET_VAL;
			rvalid_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			tctrl_ff <= nxt_tctrl;
			tcount_ff <= nxt_tcount;
			dlimit_ff <= nxt_dlimit;
			dcount_ff <= nxt_dcount;
			mctrl_ff <= nxt_mctrl;
			mval_ff <= nxt_mval;
			cctrl_ff <= nxt_cctrl;
			snap_ff <= nxt_snap;
			ectrl_ff <= nxt_ectrl;
			src_ff <= nxt_src;
			pwm_ff <= nxt_pwm;
			out_ff <= nxt_out;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign o_bus_rdata = rdata_ff;
	assign o_bus_rvalid = rvalid_ff;
	assign o_compare_outputs = out_ff;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	logic wr_tc, wr_pc, wr_ir, wr_tcr;
	assign wr_tc = i_bus_wr && (i_bus_addr == OFS_TIMER_COUNT);
	assign wr_pc = i_bus_wr && (i_bus_addr == OFS_DIV_COUNT);
	assign wr_ir = i_bus_wr && (i_bus_addr == OFS_INT_FLAGS);
	assign wr_tcr = i_bus_wr && (i_bus_addr == OFS_TIMER_CTRL);

	sequence s_match0_tick;
		tick && cmp.hit[0];
	endsequence

	// Flag set, then kept unless the flag register was written
	sequence s_flag0_seen;
		flags_ff[0] ##1 (flags_ff[0] || $past(wr_ir));
	endsequence

	a_div_steps_up: assert property (advance && !tick && !wr_pc
		|=> dcount_ff == $past(dcount_ff) + 32'h1) else $error("divider did not step");
	a_div_wraps_zero: assert property (tick && !wr_pc |=> dcount_ff == 32'h0)
		else $error("divider did not clear at limit");
	a_count_follows_tick: assert property (tick && !any_reset && !any_stop && !wr_tc
		|=> tcount_ff == $past(tcount_ff) + 32'h1) else $error("count missed a tick");
	a_count_holds_idle: assert property (!tick && !wr_tc && !tctrl_ff[TCR_RESET]
		|=> $stable(tcount_ff)) else $error("count moved without a tick");
	a_ctrl_reset_holds: assert property (tctrl_ff[TCR_RESET] && !wr_tc && !wr_pc
		|=> tcount_ff == 32'h0 && dcount_ff == 32'h0) else $error("reset bit ignored");
	a_match_sets_flag: assert property (s_match0_tick ##0 mctrl_ff[MCR_INT]
		|=> s_flag0_seen) else $error("match flag lost");
	a_match_stop_clear: assert property (any_stop && !wr_tcr |=> !tctrl_ff[TCR_ENABLE])
		else $error("stop on match did not clear enable");
	a_capture_copies_count: assert property (cap_evt |=> snap_ff == $past(tcount_ff))
		else $error("snapshot not loaded");
	a_flag_w1c_clear: assert property (wr_ir && i_bus_wdata[0] && !match_evt[0]
		|=> !flags_ff[0]) else $error("flag not cleared by one");
	a_write_wins_count: assert property (wr_tc |=> tcount_ff == $past(i_bus_wdata))
		else $error("bus write lost to increment");
	a_pwm_output_level: assert property (pwm_ff[1] && $stable(pwm_ff)
		|=> o_compare_outputs[1] == ($past(tcount_ff) >= $past(mval_ff[1])))
		else $error("pwm level wrong");
endmodule : ptmc_timer

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
	import ptmc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Stimulus rows: address, data written, value read back
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} ptmc_row_type;

	logic i_clk;
	logic i_rst;
	logic i_bus_wr;
	logic i_bus_rd;
	logic [11:0] i_bus_addr;
	logic [31:0] i_bus_wdata;
	logic [31:0] o_bus_rdata;
	logic o_bus_rvalid;
	logic i_capture_input;
	logic [3:0] o_compare_outputs;
	ptmc_row_type rows [16];
	int err_total;
	int n_tests;
	int cycles;

	ptmc_timer u_dut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_bus_wr(i_bus_wr),
		.i_bus_rd(i_bus_rd),
		.i_bus_addr(i_bus_addr),
		.i_bus_wdata(i_bus_wdata),
		.o_bus_rdata(o_bus_rdata),
		.o_bus_rvalid(o_bus_rvalid),
		.i_capture_input(i_capture_input),
		.o_compare_outputs(o_compare_outputs)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// The full sequence needs well under 2000 cycles
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			err_total = err_total + 1;
			$display("[ERR] %0t timeout", $time);
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus, pin and compare tasks
	task automatic print_verdict();
		$display("errors %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk_word

	task automatic chk_pins(input logic [3:0] exp);
		n_tests = n_tests + 1;
		if (o_compare_outputs !== exp) begin
			err_total = err_total + 1;
			$display("[ERR] %0t pins got %b want %b", $time, o_compare_outputs, exp);
		end
	endtask : chk_pins

	// Strobe rises at a falling edge, is taken at the next rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge i_clk);
		i_bus_wr = 1'b1;
		i_bus_addr = a;
		i_bus_wdata = d;
		@(negedge i_clk);
		i_bus_wr = 1'b0;
	endtask : wr

	// Read answer stands for the cycle after the taking edge
	task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp, input string what);
		@(negedge i_clk);
		i_bus_rd = 1'b1;
		i_bus_addr = a;
		@(negedge i_clk);
		i_bus_rd = 1'b0;
		chk_word({31'h0, o_bus_rvalid}, 32'h1, "rvalid");
		chk_word(o_bus_rdata, exp, what);
	endtask : chk_reg

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask : tick

	// Pulses wide enough for the two-flop synchroniser
	task automatic pulse(input int n);
		repeat (n) begin
			@(negedge i_clk);
			i_capture_input = 1'b1;
			tick(4);
			i_capture_input = 1'b0;
			tick(4);
		end
	endtask : pulse

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_bus_wr = 1'b0;
		i_bus_rd = 1'b0;
		i_bus_addr = 12'h000;
		i_bus_wdata = 32'h0;
		i_capture_input = 1'b0;
		err_total = 0;
		n_tests = 0;
		rows = '{
			'{OFS_TIMER_COUNT, 32'hdeadbeef, 32'hdeadbeef},
			'{OFS_DIV_LIMIT, 32'hffffffff, 32'hffffffff},
			'{OFS_DIV_COUNT, 32'h12345678, 32'h12345678},
			'{OFS_MATCH_CTRL, 32'hffffffff, 32'h00000fff},
			'{OFS_MATCH_VAL0, 32'ha5a5a5a5, 32'ha5a5a5a5},
			'{OFS_MATCH_VAL1, 32'h5a5a5a5a, 32'h5a5a5a5a},
			'{OFS_MATCH_VAL2, 32'h0000ffff, 32'h0000ffff},
			'{OFS_MATCH_VAL3, 32'hffff0000, 32'hffff0000},
			'{OFS_CAPT_CTRL, 32'hffffffff, 32'h00000007},
			'{OFS_CAPT_SNAP, 32'hffffffff, 32'h00000000},
			'{OFS_EXT_CTRL, 32'hffffffff, 32'h00000fff},
			'{OFS_SRC_CTRL, 32'hffffffff, 32'h0000000f},
			'{OFS_PWM_CTRL, 32'hffffffff, 32'h0000000f},
			'{OFS_INT_FLAGS, 32'hffffffff, 32'h00000000},
			'{12'h040, 32'hffffffff, 32'h00000000},
			'{OFS_TIMER_CTRL, 32'hfffffffc, 32'h00000000}
		};
		repeat (8) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		chk_pins(4'h0);
		// Reset value, write, read back for every row
		foreach (rows[i]) begin
			chk_reg(rows[i].addr, 32'h0, "reset value");
			wr(rows[i].addr, rows[i].wdata);
			chk_reg(rows[i].addr, rows[i].exp, "readback");
		end
		foreach (rows[i]) wr(rows[i].addr, 32'h0);
		// Divide by three: thirty advances give ten counts
		wr(OFS_DIV_LIMIT, 32'h2);
		wr(OFS_TIMER_CTRL, 32'h1);
		tick(28);
		wr(OFS_TIMER_CTRL, 32'h0);
		chk_reg(OFS_TIMER_COUNT, 32'h0000000a, "prescaled count");
		chk_reg(OFS_DIV_COUNT, 32'h0, "divider cleared");
		// Write to a running count wins over the increment
		wr(OFS_DIV_LIMIT, 32'h0);
		wr(OFS_TIMER_CTRL, 32'h1);
		wr(OFS_TIMER_COUNT, 32'h100);
		wr(OFS_TIMER_CTRL, 32'h0);
		chk_reg(OFS_TIMER_COUNT, 32'h102, "write precedence");
		// Reset bit holds both counts at zero
		wr(OFS_DIV_COUNT, 32'h5);
		wr(OFS_TIMER_CTRL, 32'h3);
		tick(3);
		chk_reg(OFS_TIMER_COUNT, 32'h0, "held in reset");
		chk_reg(OFS_DIV_COUNT, 32'h0, "divider held");
		wr(OFS_TIMER_CTRL, 32'h0);
		// Match on channel 2 resets the count and drives its pin low
		wr(OFS_MATCH_CTRL, 32'h80);
		wr(OFS_MATCH_VAL2, 32'h4);
		wr(OFS_EXT_CTRL, 32'h104);
		wr(OFS_TIMER_CTRL, 32'h1);
		tick(3);
		wr(OFS_TIMER_CTRL, 32'h0);
		chk_reg(OFS_TIMER_COUNT, 32'h0, "reset on match");
		chk_reg(OFS_INT_FLAGS, 32'h0, "no flag selected");
		chk_reg(OFS_EXT_CTRL, 32'h100, "pin state low");
		chk_pins(4'h0);
		// Toggle, high and none actions, then stop on channel 1
		wr(OFS_MATCH_CTRL, 32'h29);
		wr(OFS_MATCH_VAL0, 32'h3);
		wr(OFS_MATCH_VAL1, 32'h7);
		wr(OFS_MATCH_VAL3, 32'h2);
		wr(OFS_EXT_CTRL, 32'hb8);
		wr(OFS_TIMER_CTRL, 32'h1);
		tick(12);
		chk_reg(OFS_TIMER_COUNT, 32'h7, "stopped count");
		chk_reg(OFS_DIV_COUNT, 32'h0, "stopped divider");
		chk_reg(OFS_TIMER_CTRL, 32'h0, "enable cleared");
		chk_reg(OFS_INT_FLAGS, 32'h3, "match flags");
		chk_reg(OFS_EXT_CTRL, 32'hbb, "pin states");
		chk_pins(4'hb);
		wr(OFS_INT_FLAGS, 32'h1);
		chk_reg(OFS_INT_FLAGS, 32'h2, "one clears zero keeps");
		wr(OFS_INT_FLAGS, 32'h2);
		chk_reg(OFS_INT_FLAGS, 32'h0, "all cleared");
		// Capture on rising edge with flag, then falling edge only
		wr(OFS_MATCH_CTRL, 32'h0);
		wr(OFS_TIMER_COUNT, 32'h40);
		wr(OFS_CAPT_CTRL, 32'h5);
		pulse(1);
		chk_reg(OFS_CAPT_SNAP, 32'h40, "rise capture");
		chk_reg(OFS_INT_FLAGS, 32'h10, "capture flag");
		wr(OFS_CAPT_CTRL, 32'h2);
		wr(OFS_TIMER_COUNT, 32'h77);
		@(negedge i_clk);
		i_capture_input = 1'b1;
		tick(4);
		chk_reg(OFS_CAPT_SNAP, 32'h40, "rise ignored");
		@(negedge i_clk);
		i_capture_input = 1'b0;
		tick(4);
		chk_reg(OFS_CAPT_SNAP, 32'h77, "fall capture");
		chk_reg(OFS_INT_FLAGS, 32'h10, "flag sticky");
		wr(OFS_INT_FLAGS, 32'h10);
		chk_reg(OFS_INT_FLAGS, 32'h0, "capture flag cleared");
		// Counter mode on the capture input, rising then both edges
		wr(OFS_CAPT_CTRL, 32'h0);
		wr(OFS_TIMER_COUNT, 32'h0);
		wr(OFS_SRC_CTRL, 32'h1);
		wr(OFS_TIMER_CTRL, 32'h1);
		pulse(3);
		chk_reg(OFS_TIMER_COUNT, 32'h3, "rising edges counted");
		wr(OFS_SRC_CTRL, 32'h3);
		pulse(2);
		chk_reg(OFS_TIMER_COUNT, 32'h7, "both edges counted");
		// Falling edges only, then an input code that counts nothing
		wr(OFS_SRC_CTRL, 32'h2);
		pulse(1);
		chk_reg(OFS_TIMER_COUNT, 32'h8, "falling edge counted");
		wr(OFS_SRC_CTRL, 32'h7);
		pulse(1);
		chk_reg(OFS_TIMER_COUNT, 32'h8, "other input ignored");
		wr(OFS_TIMER_CTRL, 32'h0);
		wr(OFS_SRC_CTRL, 32'h0);
		// PWM output follows count against match value
		wr(OFS_EXT_CTRL, 32'h0);
		wr(OFS_MATCH_VAL0, 32'h5);
		wr(OFS_TIMER_COUNT, 32'h3);
		wr(OFS_PWM_CTRL, 32'h1);
		tick(2);
		chk_pins(4'h0);
		wr(OFS_TIMER_COUNT, 32'h9);
		tick(2);
		chk_pins(4'h1);
		// Reset in mid-run returns every register and pin to zero
		@(negedge i_clk);
		i_rst = 1'b1;
		tick(2);
		i_rst = 1'b0;
		chk_pins(4'h0);
		foreach (rows[i]) chk_reg(rows[i].addr, 32'h0, "reset again");
		print_verdict();
	end
endmodule : tb
